/* dv/otf_fault_response_tb_top.sv */
// self-checking bench for the overtemperature fault response block
`timescale 1ns/1ps
module otf_fault_response_tb_top
	import otf_pkg::*;
;
	// short ms tick keeps the long delays cheap
	localparam int TK = 4;
	logic mclk;
	logic reset;
	otf_req_t req;
	logic [7:0] rdata;
	logic rvalid;
	logic ot_fault;
	logic out_enable;
	logic fault_latched;
	int err_count;
	int checked;
	otf_fault_response #(.TICK_CYC(TK)) dut (.mclk(mclk), .reset(reset),
		.req(req), .rdata(rdata), .rvalid(rvalid), .ot_fault(ot_fault),
		.out_enable(out_enable), .fault_latched(fault_latched));
	////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// compare one result and count it
	task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// wait n falling edges
	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// one-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge mclk);
		req.wr = 1'b0;
	endtask
	// read strobe, then wait a bounded time for rvalid
	task rd(input logic [7:0] a, input logic [7:0] e);
		int i;
		@(negedge mclk);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge mclk);
		req.rd = 1'b0;
		for (i = 0; i < 3 && rvalid !== 1'b1; i++)
			@(negedge mclk);
		cmp("rvalid", 8'h01, {7'h00, rvalid});
		cmp("rdata", e, rdata);
	endtask
	// expected hold (rs=0) or restart (rs=1) time in ms per delay code
	function automatic int exp_ms(input logic [2:0] c, input logic rs);
		int t;
		t = 0;
		case (c)
			3'h0: t = rs ? 252 : 10;
			3'h1: t = rs ? 558 : 20;
			3'h2: t = rs ? 924 : 40;
			3'h3: t = rs ? 1260 : 80;
			3'h4: t = rs ? 1596 : 160;
			3'h5: t = rs ? 1932 : 320;
			3'h6: t = rs ? 2268 : 640;
			default: t = rs ? 2604 : 1280;
		endcase
		return t;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// register reset value, write, unmapped place
	task t_reg;
		rd(OTF_ADDR, OTF_RESET_VAL);
		wr(OTF_ADDR, 8'ha5);
		rd(OTF_ADDR, 8'ha5);
		wr(8'h51, 8'hff);
		rd(OTF_ADDR, 8'ha5);
		rd(8'h51, 8'h00);
		$display("test reg done");
	endtask
	// action ignore: fault has no effect
	task t_ignore;
		wr(OTF_ADDR, {ACT_IGNORE, 3'h0, 3'h0});
		ot_fault = 1'b1;
		cyc(100);
		cmp("out_enable", 8'h01, {7'h00, out_enable});
		ot_fault = 1'b0;
		cyc(5);
		$display("test ignore done");
	endtask
	// shut down, one retry, latch, then reset clears
	task t_shut;
		wr(OTF_ADDR, {ACT_SHUT, 3'h1, 3'h0});
		ot_fault = 1'b1;
		cyc(6);
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		cyc(1900);
		cmp("fault_latched", 8'h00, {7'h00, fault_latched});
		cyc(200);
		cmp("fault_latched", 8'h01, {7'h00, fault_latched});
		ot_fault = 1'b0;
		cyc(1100);
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc(2);
		cmp("fault_latched", 8'h00, {7'h00, fault_latched});
		cmp("out_enable", 8'h01, {7'h00, out_enable});
		rd(OTF_ADDR, OTF_RESET_VAL);
		$display("test shut done");
	endtask
	// ride through the 10 ms hold, then restart after 252 ms
	task t_ride;
		wr(OTF_ADDR, {ACT_RIDE, 3'h0, 3'h0});
		ot_fault = 1'b1;
		cyc(30);
		cmp("out_enable", 8'h01, {7'h00, out_enable});
		cyc(20);
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		ot_fault = 1'b0;
		cyc(900);
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		cyc(150);
		cmp("out_enable", 8'h01, {7'h00, out_enable});
		$display("test ride done");
	endtask
	// hold off while fault lasts, never latch
	task t_hold;
		wr(OTF_ADDR, {ACT_HOLD, 3'h0, 3'h0});
		ot_fault = 1'b1;
		cyc(6);
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		cyc(1300);
		cmp("fault_latched", 8'h00, {7'h00, fault_latched});
		ot_fault = 1'b0;
		cyc(6);
		cmp("out_enable", 8'h01, {7'h00, out_enable});
		$display("test hold done");
	endtask
	// every delay code: output drops at hold end, returns at restart end
	task t_delays;
		int c;
		for (c = 0; c < 8; c++)
		begin
			wr(OTF_ADDR, {ACT_RIDE, 3'h0, 3'(c)});
			ot_fault = 1'b1;
			cyc(2 + TK * exp_ms(3'(c), 1'b0));
			cmp("out_enable", 8'h01, {7'h00, out_enable});
			cyc(1);
			cmp("out_enable", 8'h00, {7'h00, out_enable});
			ot_fault = 1'b0;
			cyc(TK * exp_ms(3'(c), 1'b1) - 1);
			cmp("out_enable", 8'h00, {7'h00, out_enable});
			cyc(1);
			cmp("out_enable", 8'h01, {7'h00, out_enable});
		end
		$display("test delays done");
	endtask
	// unlimited retries never latch, restart once the fault is gone
	task t_forever;
		wr(OTF_ADDR, {ACT_SHUT, RTY_INFINITE, 3'h0});
		ot_fault = 1'b1;
		cyc(3 * TK * 252 + 10);
		cmp("fault_latched", 8'h00, {7'h00, fault_latched});
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		ot_fault = 1'b0;
		cyc(TK * 252 - 8);
		cmp("out_enable", 8'h00, {7'h00, out_enable});
		cyc(2);
		cmp("out_enable", 8'h01, {7'h00, out_enable});
		$display("test forever done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// counts and verdict, then stop
	task complete_run;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		reset = 1'b1;
		ot_fault = 1'b0;
		req = '0;
		err_count = 0;
		checked = 0;
		cyc(12);
		reset = 1'b0;
		t_reg();
		t_ignore();
		t_shut();
		t_ride();
		t_hold();
		t_delays();
		t_forever();
		complete_run();
	end
	// watchdog well beyond the expected run length
	initial
	begin
		repeat (85000) @(posedge mclk);
		err_count++;
		complete_run();
	end
endmodule

/* rtl/otf_fault_response.sv */
// overtemperature fault action controller with its configuration register
`timescale 1ns/1ps
module otf_fault_response
	import otf_pkg::*;
#(
	parameter int TICK_CYC = CYC_PER_MS
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register access, same clock domain
	input wire otf_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// fault pin and power stage control
	input wire logic ot_fault,
	output logic out_enable,
	output logic fault_latched
);
	////////////////////////////////////////////////////////////////////
	// fault pin synchroniser
	logic sync1;
	logic fault_s;
	// two flops, only the second is read
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			sync1 <= 1'b0;
			fault_s <= 1'b0;
		end
		else
		begin
			sync1 <= ot_fault;
			fault_s <= sync1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// configuration register
	logic [7:0] cfg;
	logic [7:0] next_cfg;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic hit;
	assign hit = (req.addr == OTF_ADDR);
	// write stores, read returns register, unmapped reads zero
	always_comb
	begin
		next_cfg = cfg;
		next_rdata = rdata;
		next_rvalid = req.rd;
		if (req.wr && hit)
			next_cfg = req.wdata;
		if (req.rd)
			next_rdata = hit ? cfg : 8'h00;
	end
	// register the bus state
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			cfg <= OTF_RESET_VAL;
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else
		begin
			cfg <= next_cfg;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end
	logic [1:0] act;
	logic [2:0] rty_code;
	logic [2:0] dly_code;
	assign act = cfg[OTF_ACT_HI:OTF_ACT_LO]; // R1
	assign rty_code = cfg[OTF_RTY_HI:OTF_RTY_LO]; // R5
	assign dly_code = cfg[OTF_DLY_HI:OTF_DLY_LO]; // R10
	////////////////////////////////////////////////////////////////////
	// millisecond timebase and action controller
	otf_state_t state;
	otf_state_t next_state;
	logic [15:0] pre;
	logic [15:0] next_pre;
	logic [11:0] ms;
	logic [11:0] next_ms;
	logic [2:0] left;
	logic [2:0] next_left;
	logic tick;
	logic timer_done;
	assign tick = (pre == 16'(TICK_CYC - 1));
	assign timer_done = tick && (ms == MS_ZERO);
	// next state, timer and retry counter
	always_comb
	begin
		next_state = state;
		next_pre = tick ? 16'h0000 : pre + 16'h0001;
		next_ms = (tick && ms != MS_ZERO) ? ms - 12'h001 : ms;
		next_left = left;
		case (state)
			ST_RUN:
			begin
				next_pre = 16'h0000;
				// new episode reloads retries
				next_left = rty_code; // R11
				if (fault_s)
				begin
					case (act)
						ACT_RIDE:
						begin
							next_state = ST_HOLDDLY; // R2
							next_ms = otf_hold_ms(dly_code) - 12'h001; // R9
						end
						ACT_SHUT:
						begin
							next_state = ST_WAIT; // R3
							next_ms = otf_restart_ms(dly_code) - 12'h001;
						end
						ACT_HOLD:
							next_state = ST_OFFCLR; // R4
						default:
							next_state = ST_RUN; // R1
					endcase
				end
			end
			ST_HOLDDLY:
			begin
				// fault gone during ride-through: keep running
				if (!fault_s)
					next_state = ST_RUN;
				else if (timer_done)
				begin
					next_state = ST_WAIT; // R2
					next_ms = otf_restart_ms(dly_code) - 12'h001;
				end
			end
			ST_WAIT:
			begin
				// output off, wait restart interval, then try again
				if (timer_done)
				begin
					if (!fault_s)
						next_state = ST_RUN; // R8
					else if (left == 3'h0)
						next_state = ST_LATCHED; // R6
					else
					begin
						if (left != RTY_INFINITE)
							next_left = left - 3'h1; // R5
						next_ms = otf_restart_ms(dly_code) - 12'h001; // R8
					end
				end
			end
			ST_OFFCLR:
			begin
				if (!fault_s)
					next_state = ST_RUN; // R4
			end
			ST_LATCHED:
				next_state = ST_LATCHED; // R7
			default:
				next_state = ST_RUN;
		endcase
	end
	// register controller state
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_RUN; // R7
			pre <= 16'h0000;
			ms <= MS_ZERO;
			left <= 3'h0;
		end
		else
		begin
			state <= next_state;
			pre <= next_pre;
			ms <= next_ms;
			left <= next_left;
		end
	end
	// output enable and latch flag from flops
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			out_enable <= 1'b1;
			fault_latched <= 1'b0;
		end
		else
		begin
			out_enable <= (next_state == ST_RUN)
				|| (next_state == ST_HOLDDLY);
			fault_latched <= (next_state == ST_LATCHED);
		end
	end
	////////////////////////////////////////////////////////////////////
	// checks
	AST_IGNORE: assert property (@(posedge mclk) disable iff (reset) // R1
		(state == ST_RUN && act == ACT_IGNORE) |=> state == ST_RUN)
		else $error("ignore action left run state");
	AST_RIDE: assert property (@(posedge mclk) disable iff (reset) // R2
		(state == ST_RUN && fault_s && act == ACT_RIDE)
		|=> state == ST_HOLDDLY ##1 out_enable)
		else $error("ride-through did not keep output on");
	AST_SHUT: assert property (@(posedge mclk) disable iff (reset) // R3
		(state == ST_RUN && fault_s && act == ACT_SHUT)
		|=> !out_enable && state == ST_WAIT)
		else $error("shutdown did not disable output");
	AST_HOLD: assert property (@(posedge mclk) disable iff (reset) // R4
		(state == ST_OFFCLR && !fault_s) |=> out_enable)
		else $error("output not reenabled after fault cleared");
	AST_RETRY: assert property (@(posedge mclk) disable iff (reset) // R5
		(state == ST_WAIT && timer_done && fault_s && left == RTY_INFINITE)
		|=> state == ST_WAIT && left == RTY_INFINITE)
		else $error("unlimited retries ran out");
	AST_LATCH: assert property (@(posedge mclk) disable iff (reset) // R6
		(state == ST_WAIT && timer_done && fault_s && left == 3'h0)
		|=> fault_latched && !out_enable)
		else $error("fault not latched after last retry");
	AST_STICK: assert property (@(posedge mclk) disable iff (reset) // R7
		state == ST_LATCHED |=> state == ST_LATCHED [*3])
		else $error("latched fault cleared without reset");
	AST_SPACE: assert property (@(posedge mclk) disable iff (reset) // R8
		(state == ST_WAIT && !timer_done) |=> state == ST_WAIT)
		else $error("restart attempt before interval ended");
	AST_RELOAD: assert property (@(posedge mclk) disable iff (reset) // R11
		state == ST_RUN |=> left == $past(rty_code))
		else $error("retry count not reloaded");
endmodule

/* rtl/otf_pkg.sv */
// constants and types for the overtemperature fault response block
// Overview of operation
// R1: bits 7:6 pick fault action; 00 ignores
// R2: code 01 rides hold delay, then retries
// R3: code 10 shuts down at once, retries
// R4: code 11 holds output off until clear
// R5: bits 5:3 give 0..6 retries, 7 unlimited
// R6: retries spent with fault: latch output off
// R7: latched fault cleared only by reset
// R8: restart interval spaces successive restart attempts
// R9: delay code also picks the hold delay
// R10: delay code indexes table of ms durations
// R11: fault input in, enable out; retries reload
package otf_pkg;
	// register offset and field positions
	localparam logic [7:0] OTF_ADDR = 8'h50;
	localparam int OTF_ACT_HI = 7;
	localparam int OTF_ACT_LO = 6;
	localparam int OTF_RTY_HI = 5;
	localparam int OTF_RTY_LO = 3;
	localparam int OTF_DLY_HI = 2;
	localparam int OTF_DLY_LO = 0;
	localparam logic [7:0] OTF_RESET_VAL = 8'h00;
	// action codes
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_RIDE = 2'h1;
	localparam logic [1:0] ACT_SHUT = 2'h2;
	localparam logic [1:0] ACT_HOLD = 2'h3;
	localparam logic [2:0] RTY_INFINITE = 3'h7;
	// millisecond timebase from the 40 MHz clock
	localparam int CLK_HZ = 40000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam logic [11:0] MS_ZERO = 12'h000;
	// register bus request group
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} otf_req_t;
	// controller states
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_HOLDDLY = 5'h02,
		ST_WAIT = 5'h04,
		ST_OFFCLR = 5'h08,
		ST_LATCHED = 5'h10
	} otf_state_t;
	// hold delay in ms for each delay code
	function automatic logic [11:0] otf_hold_ms(input logic [2:0] c);
		logic [11:0] t;
		t = 12'h000;
		case (c)
			3'h0: t = 12'h00a;
			3'h1: t = 12'h014;
			3'h2: t = 12'h028;
			3'h3: t = 12'h050;
			3'h4: t = 12'h0a0;
			3'h5: t = 12'h140;
			3'h6: t = 12'h280;
			default: t = 12'h500;
		endcase
		return t;
	endfunction
	// restart interval in ms for each delay code
	function automatic logic [11:0] otf_restart_ms(input logic [2:0] c);
		logic [11:0] t;
		t = 12'h000;
		case (c)
			3'h0: t = 12'h0fc;
			3'h1: t = 12'h22e;
			3'h2: t = 12'h39c;
			3'h3: t = 12'h4ec;
			3'h4: t = 12'h63c;
			3'h5: t = 12'h78c;
			3'h6: t = 12'h8dc;
			default: t = 12'ha2c;
		endcase
		return t;
	endfunction
endpackage
